/* adc_control_registers.sv */
// converter control registers with an AXI4-Lite slave and pin/core steering
// Functional notes
// - a conversion starts when software writes start high, then low
// - read-only busy flag is 1 from start until the conversion ends
// - converter enable powers the converter; 0 switches it off
// - while disabled both result bytes keep their previous contents
// - align 0: high byte bits 11..4; align 1: high byte bits 11..8
// - unused result bit positions read as zero in either alignment
// - unimplemented control bits always read as zero
// - 3-bit channel field picks one of eight external inputs
// - source codes 000/100 external, others supply or reference ratios
// - an internal source disconnects the external channel input
// - converter clock is system clock divided by two to the field
// - amplifier enable makes the internal reference usable
// - bandgap stays on while its enable or voltage monitors are on
// - two bits give the reference pins their reference function
// - reference field picks supply, pin times 1..4 or bandgap 2..4
// - a bandgap reference disconnects supply and pin reference paths
// - analog pin enable drops digital function and pull-up
// - analog pin enable overrides the port direction setting
// - conversion takes 4 sampling plus 12 converting clocks
// - completion sets the conversion request flag and pulses out
`timescale 1ns/1ps
module adc_control_registers (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [31:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [31:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [11:0]             core_result,
	input  wire logic                    lvd_on,
	input  wire logic                    lvr_on,
	input  wire logic [7:0]              pullup_req,
	input  wire logic [7:0]              port_out_req,
	output adc_ctrl_pkg::core_ctl_s      core_ctl,
	output adc_ctrl_pkg::pin_ctl_s       pin_ctl,
	output logic                         conv_done_irq
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0]  conv_control;
		logic [7:0]  conv_select;
		logic [7:0]  ref_control;
		logic [7:0]  pin_enable;
		logic [11:0] result;
		logic        busy;
		logic        go;
		logic        done_flag;
		logic        irq;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [7:0]  wdata;
		logic        wlane0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		core_ctl_s   core;
		pin_ctl_s    pins;
	} state_s;

	state_s q;
	state_s d;

	logic seq_busy;
	logic seq_sampling;
	logic seq_converting;
	logic seq_done;
	logic conv_tick;

	conv_clk_div u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (q.busy),
		.div_sel (q.conv_select[DIV_LSB +: 3]),
		.tick    (conv_tick)
	);

	conv_sequencer u_seq (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.go         (q.go),
		.enable     (q.conv_control[BIT_ENABLE]),
		.tick       (conv_tick),
		.busy       (seq_busy),
		.sampling   (seq_sampling),
		.converting (seq_converting),
		.done       (seq_done)
	);

	// high byte in [15:8], low byte in [7:0]
	function automatic logic [15:0] place_result(
		input logic [11:0] res,
		input logic        right
	);
		logic [15:0] v;
		if (right)
			v = {4'h0, res};
		else
			v = {res, 4'h0};
		return v;
	endfunction

	function automatic logic in_range(
		input logic [3:0] code,
		input logic [3:0] lo,
		input logic [3:0] hi
	);
		return (code >= lo) && (code <= hi);
	endfunction

	logic [7:0]  wr_byte;
	logic        wr_fire;
	logic [15:0] placed;
	logic [7:0]  rd_byte;
	logic        rd_ok;
	logic [2:0]  src;
	logic [3:0]  rsel;
	wire  [7:0]  pin_sel;
	wire  [7:0]  pin_pull;
	wire  [7:0]  pin_drive;

	// per-pin steering works from the stored enable: a pin changes
	// function one cycle after the write lands, traded for keeping the
	// bus write path out of the pin logic
	for (genvar p = 0; p < 8; p++) begin : g_pin
		assign pin_sel[p] = q.pin_enable[p];
		assign pin_pull[p] = pullup_req[p] & ~q.pin_enable[p];
		assign pin_drive[p] = port_out_req[p] & ~q.pin_enable[p];
	end

	// read decode of the current register contents
	always_comb begin
		placed = place_result(q.result, q.conv_control[BIT_ALIGN]);
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		case (s_axi_araddr[7:0])
			OFS_CONV_CONTROL: begin
				rd_byte = q.conv_control & MASK_CONV_CONTROL;
				rd_byte[BIT_BUSY] = q.busy;
			end
			OFS_CONV_SELECT:
				rd_byte = q.conv_select & MASK_CONV_SELECT;
			OFS_REF_CONTROL:
				rd_byte = q.ref_control & MASK_REF_CONTROL;
			OFS_PIN_ENABLE:
				rd_byte = q.pin_enable;
			OFS_RESULT_LOW:
				rd_byte = placed[7:0];
			OFS_RESULT_HIGH:
				rd_byte = placed[15:8];
			OFS_EVENT_FLAG:
				rd_byte[BIT_DONE] = q.done_flag;
			default:
				rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		d = q;
		d.go = 1'b0;
		d.irq = 1'b0;
		wr_byte = 8'h00;
		wr_fire = 1'b0;

		// write address and data may arrive in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata[7:0];
			d.wlane0 = s_axi_wstrb[0];
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;

		if (d.aw_got && d.w_got && !q.bvalid) begin
			wr_fire = d.wlane0;
			wr_byte = d.wdata;
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (d.awaddr)
				OFS_CONV_CONTROL: begin
					if (wr_fire) begin
						d.conv_control = wr_byte & MASK_CONV_CONTROL;
						// only a falling start bit launches a conversion
						if (q.conv_control[BIT_START] &&
						    !wr_byte[BIT_START] &&
						    wr_byte[BIT_ENABLE] && !q.busy) begin
							d.go = 1'b1;
							d.busy = 1'b1;
						end
					end
				end
				OFS_CONV_SELECT:
					if (wr_fire)
						d.conv_select = wr_byte & MASK_CONV_SELECT;
				OFS_REF_CONTROL:
					if (wr_fire)
						d.ref_control = wr_byte & MASK_REF_CONTROL;
				OFS_PIN_ENABLE:
					if (wr_fire)
						d.pin_enable = wr_byte;
				OFS_EVENT_FLAG:
					if (wr_fire && wr_byte[BIT_DONE])
						d.done_flag = 1'b0;
				OFS_RESULT_LOW, OFS_RESULT_HIGH: ;
				default:
					d.bresp = RESP_SLVERR;
			endcase
		end

		// completion: result lands in the same cycle busy drops
		if (seq_done && q.busy && q.conv_control[BIT_ENABLE]) begin
			d.result = core_result;
			d.busy = 1'b0;
			d.done_flag = 1'b1;
			d.irq = 1'b1;
		end
		// disabled converter drops busy and never touches the result
		if (!d.conv_control[BIT_ENABLE]) begin
			d.busy = 1'b0;
			d.go = 1'b0;
		end

		// read channel, one outstanding read
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rdata = {24'h000000, rd_byte};
			d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		d.arready = !d.rvalid;
		d.awready = !d.aw_got && !d.bvalid;
		d.wready = !d.w_got && !d.bvalid;

		// analog core steering
		src = d.conv_select[SRC_LSB +: 3];
		rsel = d.ref_control[REFSEL_LSB +: 4];
		d.core.power = d.conv_control[BIT_ENABLE];
		d.core.clk_en = conv_tick;
		d.core.sampling = seq_sampling;
		d.core.converting = seq_converting;
		d.core.ext_chan = d.conv_control[CHAN_LSB +: 3];
		d.core.int_sel = src;
		// codes 000 and 100 alone reach the external multiplexer
		d.core.ext_connect = d.conv_control[BIT_ENABLE] &&
		                     (src[1:0] == 2'h0);
		d.core.amp_on = d.ref_control[BIT_AMP];
		// monitors share the bandgap, so it cannot drop under them
		d.core.bandgap_on = d.ref_control[BIT_BANDGAP] ||
		                    lvd_on || lvr_on;
		d.core.ref_sel = rsel;
		d.core.ref_bandgap = in_range(rsel, REF_BG_LO, REF_BG_HI);
		d.core.ref_pin = in_range(rsel, REF_PIN_LO, REF_PIN_HI);
		// reserved and unlisted codes fall back to the supply
		d.core.ref_supply = !d.core.ref_bandgap &&
		                    !d.core.ref_pin;
		d.core.ref_in_pin = d.ref_control[BIT_REF_IN];
		d.core.ref_out_pin = d.ref_control[BIT_REF_OUT];

		// shared pin steering
		d.pins.analog_sel = pin_sel;
		d.pins.pullup_on = pin_pull;
		d.pins.out_en = pin_drive;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.conv_control <= RST_CONV_CONTROL;
			q.conv_select <= RST_CONV_SELECT;
			q.ref_control <= RST_REF_CONTROL;
			q.pin_enable <= RST_PIN_ENABLE;
			q.result <= RST_RESULT;
			q.core.ref_supply <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
	assign core_ctl = q.core;
	assign pin_ctl = q.pins;
	assign conv_done_irq = q.irq;
endmodule

/* adc_ctrl_pkg.sv */
// shared constants, field layouts and carrier types for the converter control
package adc_ctrl_pkg;

	// register byte offsets on the control bus
	localparam logic [7:0] OFS_CONV_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CONV_SELECT  = 8'h04;
	localparam logic [7:0] OFS_REF_CONTROL  = 8'h08;
	localparam logic [7:0] OFS_PIN_ENABLE   = 8'h0C;
	localparam logic [7:0] OFS_RESULT_LOW   = 8'h10;
	localparam logic [7:0] OFS_RESULT_HIGH  = 8'h14;
	localparam logic [7:0] OFS_EVENT_FLAG   = 8'h18;

	// values after reset
	localparam logic [7:0]  RST_CONV_CONTROL = 8'h00;
	localparam logic [7:0]  RST_CONV_SELECT  = 8'h00;
	localparam logic [7:0]  RST_REF_CONTROL  = 8'h00;
	localparam logic [7:0]  RST_PIN_ENABLE   = 8'hFF;
	localparam logic [11:0] RST_RESULT       = 12'h000;

	// stored bits; the rest read as zero except the busy flag
	localparam logic [7:0] MASK_CONV_CONTROL = 8'hB7;
	localparam logic [7:0] MASK_CONV_SELECT  = 8'hE7;
	localparam logic [7:0] MASK_REF_CONTROL  = 8'hFF;

	// field positions
	localparam int unsigned BIT_START   = 7;
	localparam int unsigned BIT_BUSY    = 6;
	localparam int unsigned BIT_ENABLE  = 5;
	localparam int unsigned BIT_ALIGN   = 4;
	localparam int unsigned CHAN_LSB    = 0;
	localparam int unsigned SRC_LSB     = 5;
	localparam int unsigned DIV_LSB     = 0;
	localparam int unsigned BIT_AMP     = 7;
	localparam int unsigned BIT_BANDGAP = 6;
	localparam int unsigned BIT_REF_IN  = 5;
	localparam int unsigned BIT_REF_OUT = 4;
	localparam int unsigned REFSEL_LSB  = 0;
	localparam int unsigned BIT_DONE    = 0;

	// reference source code ranges
	localparam logic [3:0] REF_PIN_LO = 4'h1;
	localparam logic [3:0] REF_PIN_HI = 4'h4;
	localparam logic [3:0] REF_BG_LO  = 4'hA;
	localparam logic [3:0] REF_BG_HI  = 4'hC;

	// conversion phases in converter clock cycles
	localparam logic [3:0] SAMPLE_CYCLES  = 4'h4;
	localparam logic [3:0] CONVERT_CYCLES = 4'hC;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} seq_state_e;

	// controls toward the analog core and multiplexers
	typedef struct packed {
		logic       power;
		logic       clk_en;
		logic       sampling;
		logic       converting;
		logic       ext_connect;
		logic [2:0] ext_chan;
		logic [2:0] int_sel;
		logic       amp_on;
		logic       bandgap_on;
		logic [3:0] ref_sel;
		logic       ref_supply;
		logic       ref_pin;
		logic       ref_bandgap;
		logic       ref_in_pin;
		logic       ref_out_pin;
	} core_ctl_s;

	// controls toward the shared analog input pins
	typedef struct packed {
		logic [7:0] analog_sel;
		logic [7:0] pullup_on;
		logic [7:0] out_en;
	} pin_ctl_s;

endpackage

/* conv_clk_div.sv */
// converter clock enable: one pulse every two-to-the-select system clocks
`timescale 1ns/1ps
module conv_clk_div (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	output logic            tick
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic [6:0] cnt;
		logic       tick;
	} div_state_s;

	div_state_s q;
	div_state_s d;
	logic [6:0] mask;

	always_comb begin
		mask = 7'((8'h01 << div_sel) - 8'h01);
		d = q;
		// restarting on run keeps every conversion the same length
		if (!run) begin
			d.cnt = 7'h00;
			d.tick = 1'b0;
		end else begin
			d.cnt = q.cnt + 7'h01;
			d.tick = (q.cnt & mask) == mask;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;
endmodule

/* conv_sequencer.sv */
// sample and convert phase counter driven by the converter clock enable
`timescale 1ns/1ps
module conv_sequencer (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic go,
	input  wire logic enable,
	input  wire logic tick,
	output logic      busy,
	output logic      sampling,
	output logic      converting,
	output logic      done
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		seq_state_e st;
		logic [3:0] cnt;
		logic       done;
	} seq_q_s;

	seq_q_s q;
	seq_q_s d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			SEQ_IDLE: begin
				if (go && enable) begin
					d.st = SEQ_SAMPLE;
					d.cnt = 4'h0;
				end
			end
			SEQ_SAMPLE: begin
				if (tick) begin
					d.cnt = q.cnt + 4'h1;
					if (q.cnt == SAMPLE_CYCLES - 4'h1) begin
						d.st = SEQ_CONVERT;
						d.cnt = 4'h0;
					end
				end
			end
			SEQ_CONVERT: begin
				if (tick) begin
					d.cnt = q.cnt + 4'h1;
					if (q.cnt == CONVERT_CYCLES - 4'h1) begin
						d.st = SEQ_IDLE;
						d.done = 1'b1;
					end
				end
			end
			default: d.st = SEQ_IDLE;
		endcase
		// power-down abandons the conversion without a result
		if (!enable) begin
			d.st = SEQ_IDLE;
			d.done = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '{st: SEQ_IDLE, cnt: 4'h0, done: 1'b0};
		else
			q <= d;
	end

	assign busy = q.st != SEQ_IDLE;
	assign sampling = q.st == SEQ_SAMPLE;
	assign converting = q.st == SEQ_CONVERT;
	assign done = q.done;
endmodule

/* adc_ctrl_checker.sv */
// port-level checks for the converter control register block
`timescale 1ns/1ps
module adc_ctrl_checker
	import adc_ctrl_pkg::*;
(
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire logic                    lvd_on,
	input wire logic                    lvr_on,
	input wire logic [7:0]              pullup_req,
	input wire logic [7:0]              port_out_req,
	input wire adc_ctrl_pkg::core_ctl_s core_ctl,
	input wire adc_ctrl_pkg::pin_ctl_s  pin_ctl,
	input wire logic                    conv_done_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_ext_isolate: assert property (
		core_ctl.int_sel[1:0] != 2'h0 |-> !core_ctl.ext_connect)
		else $error("external channel left connected");
	chk_ref_isolate: assert property (
		core_ctl.ref_bandgap |-> !core_ctl.ref_supply && !core_ctl.ref_pin)
		else $error("bandgap reference shares the path");
	chk_ref_decode: assert property (
		core_ctl.ref_pin == (core_ctl.ref_sel inside {[4'h1:4'h4]}))
		else $error("pin reference decode wrong");
	chk_pullup_drop: assert property (
		$past(aresetn) |-> pin_ctl.pullup_on ==
		($past(pullup_req) & ~pin_ctl.analog_sel))
		else $error("pull-up kept on analog pin");
	chk_dir_override: assert property (
		$past(aresetn) |-> pin_ctl.out_en ==
		($past(port_out_req) & ~pin_ctl.analog_sel))
		else $error("port direction not overridden");
	chk_bandgap_keep: assert property (
		$past(aresetn) && $past(lvd_on || lvr_on) |-> core_ctl.bandgap_on)
		else $error("bandgap off while monitors use it");
	chk_done_pulse: assert property (
		conv_done_irq |-> $past(core_ctl.converting) ##1 !conv_done_irq)
		else $error("completion pulse malformed");
	// phases come out two register stages behind power, so allow two cycles
	chk_power_idle: assert property (
		!core_ctl.power ##1 !core_ctl.power ##1 !core_ctl.power |->
		!core_ctl.sampling && !core_ctl.converting)
		else $error("phase active while powered off");
	chk_phase_excl: assert property (
		!(core_ctl.sampling && core_ctl.converting))
		else $error("sampling and converting overlap");
	chk_phase_order: assert property (
		$rose(core_ctl.converting) |-> $past(core_ctl.sampling))
		else $error("conversion without sampling");
endmodule

/* adc_core_model.sv */
// behavioural analog core that returns a bench-chosen code
`timescale 1ns/1ps
module adc_core_model
	import adc_ctrl_pkg::*;
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire adc_ctrl_pkg::core_ctl_s core_ctl,
	input  wire logic [11:0]             sample_val,
	output logic [11:0]                  core_result
);
	import adc_ctrl_pkg::*;
	logic conv_q;

	always @(posedge aclk)
		conv_q <= aresetn && core_ctl.converting;
	// outside a conversion the lines carry no valid code, so show the
	// inverse: a design that samples at the wrong time sees garbage
	assign core_result = (core_ctl.converting || conv_q) ?
		sample_val : ~sample_val;
endmodule

/* adc_control_registers_tb.sv */
// self-checking bench for the converter control register block
`timescale 1ns/1ps
module adc_control_registers_tb;
	import adc_ctrl_pkg::*;
	logic        aclk = 0, aresetn = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic        rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	logic [11:0] core_result, sample_val = 0;
	logic        lvd_on = 0, lvr_on = 0, irq, align, pn, bg;
	logic [7:0]  pullup_req = 0, port_out_req = 0, d, hi, lo;
	core_ctl_s   core_ctl;
	pin_ctl_s    pin_ctl;
	int          error_cnt = 0, comparisons = 0, cyc = 0, div;
	int          samp_n = 0, conv_n = 0, irq_n = 0, seed;
	int          tk_s = 0, tk_c = 0;

	always #5 aclk = ~aclk;

	adc_control_registers dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.core_result(core_result), .lvd_on(lvd_on), .lvr_on(lvr_on),
		.pullup_req(pullup_req), .port_out_req(port_out_req),
		.core_ctl(core_ctl), .pin_ctl(pin_ctl), .conv_done_irq(irq));

	adc_core_model core (.aclk(aclk), .aresetn(aresetn),
		.core_ctl(core_ctl), .sample_val(sample_val),
		.core_result(core_result));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (core_ctl.sampling === 1'b1) samp_n <= samp_n + 1;
		if (core_ctl.converting === 1'b1) conv_n <= conv_n + 1;
		if (core_ctl.clk_en === 1'b1 && core_ctl.sampling === 1'b1)
			tk_s <= tk_s + 1;
		if (core_ctl.clk_en === 1'b1 && core_ctl.converting === 1'b1)
			tk_c <= tk_c + 1;
		if (irq === 1'b1) irq_n <= irq_n + 1;
		if (cyc == 40000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic check_sig(string what, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// waits have no local bound: the cycle watchdog ends a hang
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		rsp = bresp;
	endtask

	task automatic expect_rd(logic [7:0] a, logic [7:0] v, logic [1:0] r);
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		check_sig("rdata", {24'h0, v}, rdata);
		check_sig("rresp", {30'h0, r}, {30'h0, rresp});
	endtask

	initial begin
		seed = $urandom(32'h1AC9597F);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		expect_rd(OFS_CONV_CONTROL, 8'h00, RESP_OKAY);
		expect_rd(OFS_CONV_SELECT, 8'h00, RESP_OKAY);
		expect_rd(OFS_REF_CONTROL, 8'h00, RESP_OKAY);
		expect_rd(OFS_PIN_ENABLE, 8'hFF, RESP_OKAY);
		check_sig("ref_supply", 1, core_ctl.ref_supply);
		$display("test reset values done");
		repeat (6) begin
			d = 8'($urandom) & 8'h7F;
			wr(OFS_CONV_CONTROL, d);
			expect_rd(OFS_CONV_CONTROL, d & 8'hB7, RESP_OKAY);
			d = 8'($urandom);
			wr(OFS_CONV_SELECT, d);
			expect_rd(OFS_CONV_SELECT, d & 8'hE7, RESP_OKAY);
		end
		wr(8'h1C, 8'h55);
		check_sig("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		expect_rd(8'h1C, 8'h00, RESP_SLVERR);
		$display("test masks and unmapped done");
		for (int i = 0; i < 8; i++) begin
			wr(OFS_CONV_CONTROL, 8'(i) | 8'h20);
			wr(OFS_CONV_SELECT, 8'(i << 5));
			repeat (2) @(posedge aclk);
			check_sig("ext_chan", i, 32'(core_ctl.ext_chan));
			check_sig("int_sel", i, 32'(core_ctl.int_sel));
			check_sig("ext_connect", i % 4 == 0, core_ctl.ext_connect);
		end
		$display("test input selection done");
		for (int c = 0; c < 16; c++) begin
			if (c == 9) continue;
			d = {4'($urandom), 4'(c)};
			lvd_on <= 1'($urandom);
			lvr_on <= 1'($urandom);
			wr(OFS_REF_CONTROL, d);
			expect_rd(OFS_REF_CONTROL, d, RESP_OKAY);
			pn = c inside {[1:4]};
			bg = c inside {[10:12]};
			check_sig("ref_pin", pn, core_ctl.ref_pin);
			check_sig("ref_sel", c, 32'(core_ctl.ref_sel));
			check_sig("ref_bandgap", bg, core_ctl.ref_bandgap);
			check_sig("ref_supply", !pn && !bg, core_ctl.ref_supply);
			check_sig("amp_on", d[7], core_ctl.amp_on);
			check_sig("bandgap_on", d[6] | lvd_on | lvr_on, core_ctl.bandgap_on);
			check_sig("ref_pins", d[5:4], {core_ctl.ref_in_pin, core_ctl.ref_out_pin});
		end
		$display("test reference selection done");
		repeat (4) begin
			d = 8'($urandom);
			pullup_req <= 8'($urandom);
			port_out_req <= 8'($urandom);
			wr(OFS_PIN_ENABLE, d);
			repeat (2) @(posedge aclk);
			check_sig("analog_sel", d, pin_ctl.analog_sel);
			check_sig("pullup_on", pullup_req & ~d, pin_ctl.pullup_on);
			check_sig("out_en", port_out_req & ~d, pin_ctl.out_en);
		end
		$display("test pin steering done");
		// bandgap enable written off, monitors keep their last random values; no settling wait before converting
		wr(OFS_REF_CONTROL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			div = k;
			align = k[0];
			sample_val <= 12'($urandom);
			wr(OFS_CONV_SELECT, 8'(k));
			samp_n = 0;
			conv_n = 0;
			irq_n = 0;
			tk_s = 0;
			tk_c = 0;
			wr(OFS_CONV_CONTROL, {3'b101, align, 4'h0});
			wr(OFS_CONV_CONTROL, {3'b001, align, 4'h0});
			expect_rd(OFS_CONV_CONTROL, {3'b011, align, 4'h0}, RESP_OKAY);
			while (irq_n == 0) @(posedge aclk);
			hi = align ? {4'h0, sample_val[11:8]} : sample_val[11:4];
			lo = align ? sample_val[7:0] : {sample_val[3:0], 4'h0};
			expect_rd(OFS_RESULT_HIGH, hi, RESP_OKAY);
			expect_rd(OFS_RESULT_LOW, lo, RESP_OKAY);
			check_sig("sample_len", 4 << div, samp_n);
			check_sig("convert_len", 12 << div, conv_n);
			check_sig("sample_ticks", 4, tk_s);
			check_sig("convert_ticks", 12, tk_c);
			expect_rd(OFS_CONV_CONTROL, {3'b001, align, 4'h0}, RESP_OKAY);
			expect_rd(OFS_EVENT_FLAG, 8'h01, RESP_OKAY);
			wr(OFS_EVENT_FLAG, 8'h01);
			expect_rd(OFS_EVENT_FLAG, 8'h00, RESP_OKAY);
			check_sig("done_pulses", 1, irq_n);
		end
		$display("test conversions done");
		sample_val <= ~sample_val;
		wr(OFS_CONV_CONTROL, 8'hB0);
		wr(OFS_CONV_CONTROL, 8'h30);
		repeat (20) @(posedge aclk);
		wr(OFS_CONV_CONTROL, 8'h10);
		expect_rd(OFS_CONV_CONTROL, 8'h10, RESP_OKAY);
		check_sig("power", 0, core_ctl.power);
		expect_rd(OFS_RESULT_HIGH, hi, RESP_OKAY);
		expect_rd(OFS_RESULT_LOW, lo, RESP_OKAY);
		samp_n = 0;
		wr(OFS_CONV_CONTROL, 8'h90);
		wr(OFS_CONV_CONTROL, 8'h10);
		wr(OFS_CONV_CONTROL, 8'h30);
		repeat (40) @(posedge aclk);
		check_sig("sample_len", 0, samp_n);
		$display("test abort and false starts done");
		give_verdict();
	end
endmodule

bind adc_control_registers adc_ctrl_checker chk (.aclk(aclk),
	.aresetn(aresetn), .lvd_on(lvd_on), .lvr_on(lvr_on),
	.pullup_req(pullup_req), .port_out_req(port_out_req),
	.core_ctl(core_ctl), .pin_ctl(pin_ctl), .conv_done_irq(conv_done_irq));
